// ---- hw/pfs_defines.vh ----
// Register offsets, field positions, reset values and code points for the pin function selector
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH
`define PFS_OFS_SEL0 8'h00
`define PFS_OFS_SEL1 8'h04
`define PFS_OFS_INSRC 8'h08
`define PFS_OFS_PA_DATA 8'h0C
`define PFS_OFS_PA_DIR 8'h10
`define PFS_OFS_PB_DATA 8'h14
`define PFS_OFS_PB_DIR 8'h18
`define PFS_OFS_PA_WAKE 8'h1C
`define PFS_OFS_BITOP 8'h20
`define PFS_OFS_SLEEP 8'h24
`define PFS_SEL_RESET 8'h00
`define PFS_PORT_RESET 8'hFF
`define PFS_SEL1_MASK 8'h3C
`define PFS_INSRC_MASK 8'h0F
`define PFS_CODE_ALT 2'h3
`define PFS_CODE_AN1 2'h2
`define PFS_F_L3 3'h6
`define PFS_F_L2 3'h4
`define PFS_F_L1 3'h2
`define PFS_F_L0 3'h0
`define PFS_F_L6 3'h4
`define PFS_F_L5 3'h2
`define PFS_B_CAP 3
`define PFS_B_TCK 2
`define PFS_B_IRQ1 1
`define PFS_B_IRQ0 0
`define PFS_RESP_OKAY 2'h0
`define PFS_RESP_SLVERR 2'h2
`endif

// ---- hw/pfs_regs.v ----
// Port data and direction register pair with whole-byte read-modify-write of one bit
`timescale 1ns/1ps
`include "pfs_defines.vh"
module pfs_regs
#(
  parameter WIDTH = 8
)
(
  input wire clk,
  input wire rst_n,
  input wire data_we,
  input wire dir_we,
  input wire [WIDTH-1:0] wdata,
  input wire bit_we,
  input wire bit_sel_dir,
  input wire [2:0] bit_idx,
  input wire bit_val,
  input wire [WIDTH-1:0] pin_level,
  output reg [WIDTH-1:0] data,
  output reg [WIDTH-1:0] dir,
  output wire [WIDTH-1:0] readback
);
  reg [WIDTH-1:0] whole;
  reg [WIDTH-1:0] next_whole;

  // Input lines show the pin, output lines show the latch
  assign readback = (dir & pin_level) | (~dir & data);

  always @*
  begin
    whole = bit_sel_dir ? dir : readback;
    next_whole = whole;
    next_whole[bit_idx] = bit_val;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      data <= {WIDTH{1'b1}};
      dir <= {WIDTH{1'b1}};
    end
    else
    begin
      if (data_we)
        data <= wdata;
      else if (bit_we && !bit_sel_dir)
        data <= next_whole;
      if (dir_we)
        dir <= wdata;
      else if (bit_we && bit_sel_dir)
        dir <= next_whole;
    end
  end
endmodule // pfs_regs

// ---- hw/pfs_sync.v ----
// Three-stage input synchroniser that accepts a change when stages two and three agree
`timescale 1ns/1ps
module pfs_sync
#(
  parameter WIDTH = 8
)
(
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  integer i;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1 <= {WIDTH{1'b1}};
      s2 <= {WIDTH{1'b1}};
      s3 <= {WIDTH{1'b1}};
      dout <= {WIDTH{1'b1}};
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (i = 0; i < WIDTH; i = i + 1)
        if (s2[i] == s3[i])
          dout[i] <= s3[i];
    end
  end
endmodule // pfs_sync

// ---- hw/pfs_top.v ----
// Pin function selector: routing registers, ports A and B, wake-up, AXI4-Lite slave
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pfs_defines.vh"
// How it works
// - Select 0 bits 7..6: line 3 analog on 11
// - Select 0 bits 5..4: line 2 analog on 11
// - Select 0 bits 3..2: line 1 analog/reference
// - Select 0 bits 1..0: line 0 analog on 11
// - Select 1 bits 5..4: line 6 timer output
// - Select 1 bits 3..2: line 5 inverted output
// - Unimplemented bits read zero, ignore writes
// - Source bit 3: capture from line 4/5
// - Source bit 2: timer clock from A3/B4
// - Source bit 1: irq1 from A4/B3
// - Source bit 0: irq0 from A3/B2
// - Inverted pin always complements main output
// - Port data and direction reset to ones
// - Bit set/clear is whole-byte read-modify-write
// - Falling edge on woken line wakes device
// - Direction 1 input, 0 CMOS output
module pfs_top
(
  input wire CORE_CLK,
  input wire RSTN,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [7:0] PA_IN,
  output reg [7:0] PA_OUT,
  output reg [7:0] PA_OE,
  input wire [7:0] PB_IN,
  output reg [7:0] PB_OUT,
  output reg [7:0] PB_OE,
  output reg [3:0] ANALOG_CHANNEL_EN,
  output reg REFERENCE_INPUT_EN,
  input wire TIMER_MAIN_OUTPUT,
  output reg TIMER_EXTERNAL_CLOCK_INPUT,
  output reg TIMER_CAPTURE_INPUT,
  output reg EXTERNAL_INTERRUPT_0,
  output reg EXTERNAL_INTERRUPT_1,
  output reg WAKE_UP
);
  reg [7:0] port_a_output_select_0;
  reg [7:0] port_a_output_select_1;
  reg [7:0] input_source_select;
  reg [7:0] pa_wake;
  reg sleep_mode;
  reg [7:0] pa_prev;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [7:0] pa_sync;
  wire [7:0] pb_sync;
  wire [7:0] pa_data;
  wire [7:0] pa_dir;
  wire [7:0] pa_rb;
  wire [7:0] pb_data;
  wire [7:0] pb_dir;
  wire [7:0] pb_rb;
  wire do_write;
  wire wr_lane0;
  wire bitop_we;
  reg [7:0] next_pa_out;
  reg [7:0] next_pa_oe;
  reg [7:0] next_rdata;
  reg rd_hit;

  function alt_code;
    input [7:0] reg_val;
    input [2:0] pos;
    begin
      alt_code = (reg_val[pos +: 2] == `PFS_CODE_ALT);
    end
  endfunction

  function wr_known;
    input [7:0] addr;
    begin
      wr_known = (addr == `PFS_OFS_SEL0) || (addr == `PFS_OFS_SEL1) || (addr == `PFS_OFS_INSRC) ||
                 (addr == `PFS_OFS_PA_DATA) || (addr == `PFS_OFS_PA_DIR) || (addr == `PFS_OFS_PB_DATA) ||
                 (addr == `PFS_OFS_PB_DIR) || (addr == `PFS_OFS_PA_WAKE) || (addr == `PFS_OFS_BITOP) ||
                 (addr == `PFS_OFS_SLEEP);
    end
  endfunction

  pfs_sync #(.WIDTH(8)) u_sync_a
  (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .din(PA_IN),
    .dout(pa_sync)
  );

  pfs_sync #(.WIDTH(8)) u_sync_b
  (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .din(PB_IN),
    .dout(pb_sync)
  );

  // Both channels must be held before a write commits; either may arrive first
  assign do_write = aw_held && w_held && !S_AXI_BVALID;
  assign wr_lane0 = do_write && w_strb[0];
  // Bit op word: [0] value, [3:1] index, [4] 1=direction, [5] 1=port B
  assign bitop_we = wr_lane0 && (aw_addr == `PFS_OFS_BITOP);

  pfs_regs #(.WIDTH(8)) u_port_a
  (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .data_we(wr_lane0 && (aw_addr == `PFS_OFS_PA_DATA)),
    .dir_we(wr_lane0 && (aw_addr == `PFS_OFS_PA_DIR)),
    .wdata(w_data[7:0]),
    .bit_we(bitop_we && !w_data[5]),
    .bit_sel_dir(w_data[4]),
    .bit_idx(w_data[3:1]),
    .bit_val(w_data[0]),
    .pin_level(pa_sync),
    .data(pa_data),
    .dir(pa_dir),
    .readback(pa_rb)
  );

  pfs_regs #(.WIDTH(8)) u_port_b
  (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .data_we(wr_lane0 && (aw_addr == `PFS_OFS_PB_DATA)),
    .dir_we(wr_lane0 && (aw_addr == `PFS_OFS_PB_DIR)),
    .wdata(w_data[7:0]),
    .bit_we(bitop_we && w_data[5]),
    .bit_sel_dir(w_data[4]),
    .bit_idx(w_data[3:1]),
    .bit_val(w_data[0]),
    .pin_level(pb_sync),
    .data(pb_data),
    .dir(pb_dir),
    .readback(pb_rb)
  );

  always @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `PFS_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      port_a_output_select_0 <= `PFS_SEL_RESET;
      port_a_output_select_1 <= `PFS_SEL_RESET;
      input_source_select <= `PFS_SEL_RESET;
      pa_wake <= 8'h00;
      sleep_mode <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_known(aw_addr) ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
        if (w_strb[0])
        begin
          case (aw_addr)
            `PFS_OFS_SEL0: port_a_output_select_0 <= w_data[7:0];
            `PFS_OFS_SEL1: port_a_output_select_1 <= w_data[7:0] & `PFS_SEL1_MASK;
            `PFS_OFS_INSRC: input_source_select <= w_data[7:0] & `PFS_INSRC_MASK;
            `PFS_OFS_PA_WAKE: pa_wake <= w_data[7:0];
            `PFS_OFS_SLEEP: sleep_mode <= w_data[0];
            default: sleep_mode <= sleep_mode;
          endcase
        end
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      // A wake event ends sleep; it wins over a software write in the same cycle
      if (WAKE_UP)
        sleep_mode <= 1'b0;
    end
  end

  always @*
  begin
    rd_hit = 1'b1;
    case ({S_AXI_ARADDR[7:2], 2'b00})
      `PFS_OFS_SEL0: next_rdata = port_a_output_select_0;
      `PFS_OFS_SEL1: next_rdata = port_a_output_select_1;
      `PFS_OFS_INSRC: next_rdata = input_source_select;
      `PFS_OFS_PA_DATA: next_rdata = pa_rb;
      `PFS_OFS_PA_DIR: next_rdata = pa_dir;
      `PFS_OFS_PB_DATA: next_rdata = pb_rb;
      `PFS_OFS_PB_DIR: next_rdata = pb_dir;
      `PFS_OFS_PA_WAKE: next_rdata = pa_wake;
      `PFS_OFS_BITOP: next_rdata = 8'h00;
      `PFS_OFS_SLEEP: next_rdata = {7'h00, sleep_mode};
      default:
      begin
        next_rdata = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `PFS_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h00_0000, next_rdata};
        S_AXI_RRESP <= rd_hit ? `PFS_RESP_OKAY : `PFS_RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // Pin drive: analog and reference functions release the driver; digital inputs rely on the direction bit
  always @*
  begin
    next_pa_out = pa_data;
    next_pa_oe = ~pa_dir;
    if (alt_code(port_a_output_select_0, `PFS_F_L3))
      next_pa_oe[3] = 1'b0;
    if (alt_code(port_a_output_select_0, `PFS_F_L2))
      next_pa_oe[2] = 1'b0;
    if (port_a_output_select_0[`PFS_F_L1 +: 2] >= `PFS_CODE_AN1)
      next_pa_oe[1] = 1'b0;
    if (alt_code(port_a_output_select_0, `PFS_F_L0))
      next_pa_oe[0] = 1'b0;
    if (alt_code(port_a_output_select_1, `PFS_F_L6))
    begin
      next_pa_out[6] = TIMER_MAIN_OUTPUT;
      next_pa_oe[6] = 1'b1;
    end
    if (alt_code(port_a_output_select_1, `PFS_F_L5))
    begin
      next_pa_out[5] = ~TIMER_MAIN_OUTPUT;
      next_pa_oe[5] = 1'b1;
    end
  end

  // All routing is registered, so each pin changes once, one cycle after the write
  always @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      PA_OUT <= `PFS_PORT_RESET;
      PA_OE <= 8'h00;
      PB_OUT <= `PFS_PORT_RESET;
      PB_OE <= 8'h00;
      ANALOG_CHANNEL_EN <= 4'h0;
      REFERENCE_INPUT_EN <= 1'b0;
      TIMER_EXTERNAL_CLOCK_INPUT <= 1'b1;
      TIMER_CAPTURE_INPUT <= 1'b1;
      EXTERNAL_INTERRUPT_0 <= 1'b1;
      EXTERNAL_INTERRUPT_1 <= 1'b1;
      WAKE_UP <= 1'b0;
      pa_prev <= 8'hFF;
    end
    else
    begin
      PA_OUT <= next_pa_out;
      PA_OE <= next_pa_oe;
      PB_OUT <= pb_data;
      PB_OE <= ~pb_dir;
      ANALOG_CHANNEL_EN[3] <= alt_code(port_a_output_select_0, `PFS_F_L3);
      ANALOG_CHANNEL_EN[2] <= alt_code(port_a_output_select_0, `PFS_F_L2);
      ANALOG_CHANNEL_EN[1] <= (port_a_output_select_0[`PFS_F_L1 +: 2] == `PFS_CODE_AN1);
      ANALOG_CHANNEL_EN[0] <= alt_code(port_a_output_select_0, `PFS_F_L0);
      REFERENCE_INPUT_EN <= alt_code(port_a_output_select_0, `PFS_F_L1);
      // Digital inputs share the GPIO code; software keeps the direction bit at input
      TIMER_CAPTURE_INPUT <= input_source_select[`PFS_B_CAP] ? pa_sync[5] : pa_sync[4];
      TIMER_EXTERNAL_CLOCK_INPUT <= input_source_select[`PFS_B_TCK] ? pb_sync[4] : pa_sync[3];
      EXTERNAL_INTERRUPT_1 <= input_source_select[`PFS_B_IRQ1] ? pb_sync[3] : pa_sync[4];
      EXTERNAL_INTERRUPT_0 <= input_source_select[`PFS_B_IRQ0] ? pb_sync[2] : pa_sync[3];
      pa_prev <= pa_sync;
      // Edge is on the filtered level, so a glitch seen at only one clock edge never wakes
      WAKE_UP <= sleep_mode && |(pa_wake & pa_prev & ~pa_sync);
    end
  end
endmodule // pfs_top

// ---- verification/pfs_pin_model.sv ----
// Pad model for ports A and B
`timescale 1ns/1ps
module pfs_pin_model
(
  input wire [7:0] pa_out,
  input wire [7:0] pa_oe,
  input wire [7:0] pb_out,
  input wire [7:0] pb_oe,
  input wire [7:0] ext_a,
  input wire [7:0] ext_b,
  output wire [7:0] pa_in,
  output wire [7:0] pb_in
);
  // Released lines follow the bench pattern, never the last driven level
  assign pa_in = (pa_out & pa_oe) | (ext_a & ~pa_oe);
  assign pb_in = (pb_out & pb_oe) | (ext_b & ~pb_oe);
endmodule // pfs_pin_model

// ---- verification/pfs_top_checker.sv ----
// Concurrent checks on the pin function selector ports
`timescale 1ns/1ps
module pfs_top_checker
(
  input wire CORE_CLK,
  input wire RSTN,
  input wire [7:0] PA_IN,
  input wire [7:0] PB_IN,
  input wire [7:0] PA_OUT,
  input wire [7:0] PA_OE,
  input wire [7:0] PB_OUT,
  input wire [3:0] ANALOG_CHANNEL_EN,
  input wire REFERENCE_INPUT_EN,
  input wire TIMER_EXTERNAL_CLOCK_INPUT,
  input wire TIMER_CAPTURE_INPUT,
  input wire EXTERNAL_INTERRUPT_0,
  input wire EXTERNAL_INTERRUPT_1,
  input wire WAKE_UP
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  an3_off_a: assert property (ANALOG_CHANNEL_EN[3] |-> !PA_OE[3]) else $error("analog 3 driven");
  an2_off_a: assert property (ANALOG_CHANNEL_EN[2] |-> !PA_OE[2]) else $error("analog 2 driven");
  ref_pin_a: assert property (REFERENCE_INPUT_EN |-> !PA_OE[1] && !ANALOG_CHANNEL_EN[1])
    else $error("reference pin driven");
  an0_off_a: assert property (ANALOG_CHANNEL_EN[0] |-> !PA_OE[0]) else $error("analog 0 driven");
  // Pins equal on both candidates, so the routing holds whatever the choice bit is
  cap_route_a: assert property ((PA_IN[4] == PA_IN[5] && $stable(PA_IN))[*7]
    |-> TIMER_CAPTURE_INPUT == PA_IN[4]) else $error("capture route");
  tck_route_a: assert property ((PA_IN[3] == PB_IN[4] && $stable(PA_IN) && $stable(PB_IN))[*7]
    |-> TIMER_EXTERNAL_CLOCK_INPUT == PA_IN[3]) else $error("clock route");
  irq1_route_a: assert property ((PA_IN[4] == PB_IN[3] && $stable(PA_IN) && $stable(PB_IN))[*7]
    |-> EXTERNAL_INTERRUPT_1 == PA_IN[4]) else $error("irq1 route");
  irq0_route_a: assert property ((PA_IN[3] == PB_IN[2] && $stable(PA_IN) && $stable(PB_IN))[*7]
    |-> EXTERNAL_INTERRUPT_0 == PA_IN[3]) else $error("irq0 route");
  port_reset_a: assert property ($rose(RSTN) |-> PA_OUT == 8'hFF && PB_OUT == 8'hFF && PA_OE == 8'h00)
    else $error("port reset");
  wake_pulse_a: assert property (WAKE_UP |=> !WAKE_UP) else $error("wake too long");
endmodule // pfs_top_checker
bind pfs_top pfs_top_checker u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PA_IN(PA_IN), .PB_IN(PB_IN),
  .PA_OUT(PA_OUT), .PA_OE(PA_OE), .PB_OUT(PB_OUT), .ANALOG_CHANNEL_EN(ANALOG_CHANNEL_EN),
  .REFERENCE_INPUT_EN(REFERENCE_INPUT_EN), .TIMER_EXTERNAL_CLOCK_INPUT(TIMER_EXTERNAL_CLOCK_INPUT),
  .TIMER_CAPTURE_INPUT(TIMER_CAPTURE_INPUT), .EXTERNAL_INTERRUPT_0(EXTERNAL_INTERRUPT_0),
  .EXTERNAL_INTERRUPT_1(EXTERNAL_INTERRUPT_1), .WAKE_UP(WAKE_UP));

// ---- verification/pfs_top_tb.sv ----
// Self-checking bench for the pin function selector
`timescale 1ns/1ps
module pfs_top_tb;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, tmo = 0;
  logic awr, wr_r, bv, arr, rv, ref_en, tck, cap, irq0, irq1, wake;
  logic [7:0] awa = 0, ara = 0, pa_ext = 0, pb_ext = 0, pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe, v, e;
  logic [31:0] wd = 0, rdata;
  logic [1:0] bresp, rresp, r;
  logic [3:0] an, ws = 4'hF;
  logic [7:0] mk [3] = '{8'hFF, 8'h3C, 8'h0F};
  int n_mismatch = 0, comparisons = 0, k;
  always #2 clk = ~clk;
  pfs_top DUT (.CORE_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .PA_IN(pa_in),
    .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe), .ANALOG_CHANNEL_EN(an),
    .REFERENCE_INPUT_EN(ref_en), .TIMER_MAIN_OUTPUT(tmo), .TIMER_EXTERNAL_CLOCK_INPUT(tck),
    .TIMER_CAPTURE_INPUT(cap), .EXTERNAL_INTERRUPT_0(irq0), .EXTERNAL_INTERRUPT_1(irq1), .WAKE_UP(wake));
  pfs_pin_model pads (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe), .ext_a(pa_ext),
    .ext_b(pb_ext), .pa_in(pa_in), .pb_in(pb_in));
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang(input logic late);
    if (late)
    begin
      n_mismatch++;
      conclude();
    end
  endtask
  // Bready stays up from the start, so the answer is taken at the edge it is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bready <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
    end
    while (!bv && n < 99);
    resp = bresp;
    bready <= 0;
    hang(!bv);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rready <= 1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arr) arv <= 0;
    end
    while (!rv && n < 99);
    d = rdata[7:0];
    rready <= 0;
    hang(!rv);
  endtask
  function automatic logic [3:0] an_exp(input logic [1:0] c);
    an_exp = c == 2'h3 ? 4'hD : (c == 2'h2 ? 4'h2 : 4'h0);
  endfunction
  function automatic logic [3:0] route(input logic [3:0] s, input logic [7:0] a, input logic [7:0] b);
    route = {s[3] ? a[5] : a[4], s[2] ? b[4] : a[3], s[1] ? b[3] : a[4], s[0] ? b[2] : a[3]};
  endfunction
  initial
  begin
    void'($urandom(32'h7a0b));
    repeat (2) @(posedge clk);
    rstn <= 1;
    rd(8'h10, v);
    chk8(v, 8'hFF);
    for (int i = 0; i < 3; i++)
    begin
      rd(8'(4 * i), v);
      chk8(v, 8'h00);
      wr(8'(4 * i), 8'hFF, r);
      rd(8'(4 * i), v);
      chk8(v, mk[i]);
      wr(8'(4 * i), 8'h00, r);
    end
    for (int c = 3; c >= 0; c--)
    begin
      wr(8'h00, {4{c[1:0]}}, r);
      repeat (3) @(posedge clk);
      chk8({4'h0, an}, {4'h0, an_exp(c[1:0])});
      chk8({7'h0, ref_en}, {7'h0, c == 3});
    end
    // Direction bits stay input from reset while pins feed routed inputs
    for (int i = 0; i < 12; i++)
    begin
      v = 8'($urandom_range(15));
      wr(8'h08, v, r);
      pa_ext <= 8'($urandom);
      pb_ext <= 8'($urandom);
      repeat (8) @(posedge clk);
      chk8({4'h0, cap, tck, irq1, irq0}, {4'h0, route(v[3:0], pa_ext, pb_ext)});
    end
    // Pin selected before the output toggles and released after it stops
    wr(8'h04, 8'h3C, r);
    for (int i = 0; i < 6; i++)
    begin
      tmo <= 1'($urandom_range(1));
      repeat (2) @(posedge clk);
      chk8({6'h0, pa_out[6:5]}, {6'h0, tmo, ~tmo});
      chk8({6'h0, pa_oe[6:5]}, 8'h03);
    end
    tmo <= 0;
    wr(8'h04, 8'h00, r);
    pa_ext <= 8'($urandom);
    repeat (8) @(posedge clk);
    e = pa_ext | 8'h80;
    wr(8'h20, 8'h0F, r);
    wr(8'h10, 8'h00, r);
    rd(8'h0C, v);
    chk8(v, e);
    chk8(pa_out, e);
    chk8(pa_oe, 8'hFF);
    wr(8'h10, 8'hFF, r);
    chk_resp(r, 2'h0);
    pa_ext <= 8'h01;
    wr(8'h1C, 8'h01, r);
    wr(8'h24, 8'h01, r);
    repeat (6) @(posedge clk);
    pa_ext <= 8'h00;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (!wake && k < 12);
    chk8({7'h0, wake}, 8'h01);
    rd(8'h24, v);
    chk8(v, 8'h00);
    // Lane 0 disabled: answered, but the wake enables keep their value
    ws <= 4'h0;
    wr(8'h1C, 8'hAA, r);
    ws <= 4'hF;
    chk_resp(r, 2'h0);
    rd(8'h1C, v);
    chk8(v, 8'h01);
    // Port B: latch on outputs, pin on the line that a bit op turns back to input
    v = 8'($urandom);
    wr(8'h14, v, r);
    wr(8'h18, 8'h00, r);
    wr(8'h20, 8'h31, r);
    rd(8'h18, e);
    chk8(e, 8'h01);
    chk8(pb_out, v);
    chk8(pb_oe, 8'hFE);
    rd(8'h14, e);
    chk8(e, {v[7:1], pb_ext[0]});
    wr(8'h18, 8'hFF, r);
    wr(8'h30, 8'h55, r);
    chk_resp(r, 2'h2);
    rd(8'h30, v);
    chk8(v, 8'h00);
    chk_resp(rresp, 2'h2);
    // Reset again in mid-run: ports return to inputs with latches high
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    rd(8'h18, v);
    chk8(v, 8'hFF);
    chk8(pb_out, 8'hFF);
    chk8(pa_oe, 8'h00);
    conclude();
  end
endmodule // pfs_top_tb
